/* verilog/cfs_consts.svh */
// constants of the clock fan-out select and gate block
`ifndef CFS_CONSTS_SVH
`define CFS_CONSTS_SVH

`define CFS_NUM_OUTPUTS 12
`define CFS_SEL_DIFF 1'b0
`define CFS_SEL_TEST 1'b1
`define CFS_OE_RESET 1'b0
`define CFS_OUT_RESET 1'b0

`endif

/* verilog/cfs_pkg.sv */
// types of the clock fan-out select and gate block
package cfs_pkg;

    // two-flop synchroniser for one pin
    typedef struct packed {
        logic s1;
        logic s2;
    } cfs_sync_t;

    // whole state of the block
    typedef struct packed {
        cfs_sync_t ref_p;
        cfs_sync_t ref_n;
        cfs_sync_t test;
        cfs_sync_t sel;
        cfs_sync_t oe;
        cfs_sync_t flt_n;
        logic sel_clk_prev;
        logic oe_cap;
        logic [11:0] out;
        logic [11:0] out_en;
    } cfs_state_t;

endpackage : cfs_pkg

/* verilog/cfs_fanout.sv */
// clock source select, synchronous output gate and float control for twelve outputs
// How it works
// R1: low select routes differential reference clock, high select routes test clock.
// R2: enable captured on selected clock falling edge; only captured value gates outputs.
// R3: captured enable high lets every output follow the selected clock.
// R4: captured enable low holds every output steadily low.
// R5: enable changes never cut a pulse short or make a glitch.
// R6: float control low puts every output into high impedance.
// R7: float control high drives outputs, which the enable then governs.
// R8: twelve identical outputs all carry the same selected clock.
// R9: captured enable changes only while selected clock is low.
`timescale 1ns/1ps
`include "cfs_consts.svh"

module cfs_fanout
    import cfs_pkg::*;
#(
    parameter int NUM_OUT = `CFS_NUM_OUTPUTS
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic diff_ref_clk_p,
    input wire logic diff_ref_clk_n,
    input wire logic test_clk_in,
    input wire logic clk_source_select,
    input wire logic sync_out_enable,
    input wire logic output_float_n,
    output logic [NUM_OUT-1:0] clk_out,
    output logic [NUM_OUT-1:0] clk_out_oe
);

    cfs_state_t state_q;
    cfs_state_t state_d;
    logic sel_clk;
    logic fall_det;

    // reset image: outputs parked low and floated until the pins have been seen
    localparam cfs_state_t STATE_RESET = '{
        ref_p: '0,
        ref_n: '0,
        test: '0,
        sel: '0,
        oe: '0,
        flt_n: '0,
        sel_clk_prev: 1'h0,
        oe_cap: `CFS_OE_RESET,
        out: {`CFS_NUM_OUTPUTS{`CFS_OUT_RESET}},
        out_en: '0
    };

    // limitations a user must know:
    // pins are sampled by sys_clk, so pin clocks must stay well below its rate
    // each pin phase must last several sampling cycles or it may be missed
    // outputs lag the pin clock by three sampling cycles, with one cycle of jitter
    // float goes through the synchroniser too: no async path, two cycles slower
    // source switching is unprotected; park the outputs before changing it
    // the differential pair reads high only while p is high and n is low
    // clk_en low also stops the synchronisers, so stale pin levels are kept

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // one step of a two-flop synchroniser; logic reads s2 only, never s1
    function automatic cfs_sync_t cfs_sync_step(input cfs_sync_t cur, input logic pin);
        cfs_sync_t nxt;
        nxt.s1 = pin;
        nxt.s2 = cur.s1;
        return nxt;
    endfunction : cfs_sync_step

    ////////////////////////////////////////////////////////////////////////
    // sampled view of the pins

    // mux reads only the second synchroniser stage
    always_comb begin
        if (state_q.sel.s2 == `CFS_SEL_TEST) begin
            sel_clk = state_q.test.s2; // see R1
        end else begin
            sel_clk = state_q.ref_p.s2 & ~state_q.ref_n.s2; // see R1
        end
        // falling edge of the selected clock as seen after synchronising
        fall_det = state_q.sel_clk_prev & ~sel_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        state_d = state_q;
        // every pin crosses into the sampling domain through two flops
        state_d.ref_p = cfs_sync_step(state_q.ref_p, diff_ref_clk_p);
        state_d.ref_n = cfs_sync_step(state_q.ref_n, diff_ref_clk_n);
        state_d.test = cfs_sync_step(state_q.test, test_clk_in);
        state_d.sel = cfs_sync_step(state_q.sel, clk_source_select);
        state_d.oe = cfs_sync_step(state_q.oe, sync_out_enable);
        state_d.flt_n = cfs_sync_step(state_q.flt_n, output_float_n);
        state_d.sel_clk_prev = sel_clk;
        // capture only at the falling edge, so the clock is low when the gate moves
        if (fall_det) begin
            state_d.oe_cap = state_q.oe.s2; // see R2, R9
        end
        // gate with the old captured value; a disable lands while the clock is low
        state_d.out = {NUM_OUT{sel_clk & state_q.oe_cap}}; // see R3, R4, R5, R8
        // float is asynchronous in spirit but sampled here, costs two cycles latency
        state_d.out_en = {NUM_OUT{state_q.flt_n.s2}}; // see R6, R7
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    // one register for the whole state; clk_en low freezes all of it
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= STATE_RESET;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // outputs come straight from the registered state
    assign clk_out = state_q.out;
    assign clk_out_oe = state_q.out_en;

    ////////////////////////////////////////////////////////////////////////
    // checks

    // all checks run on the sampling clock and rest during reset
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // checks look at the registered view only, never at raw pins
    route_test_clk_a: assert property ( // see R1
        clk_en && state_q.sel.s2 && state_q.oe_cap && state_q.test.s2 && state_q.flt_n.s2
        |=> clk_out[0] == 1'b1)
        else $error("test clock not routed");
    capture_on_fall_a: assert property ( // see R2
        clk_en && !fall_det |=> $stable(state_q.oe_cap))
        else $error("enable captured outside falling edge");
    follow_enabled_a: assert property ( // see R3
        clk_en && state_q.oe_cap && sel_clk |=> &clk_out)
        else $error("enabled outputs not following clock");
    park_low_a: assert property ( // see R4
        clk_en && !state_q.oe_cap ##1 clk_en && !state_q.oe_cap |=> clk_out == '0)
        else $error("disabled outputs not low");
    no_runt_a: assert property ( // see R5
        $fell(clk_out[0]) |-> !$past(sel_clk))
        else $error("output fell while clock high");
    float_outputs_a: assert property ( // see R6
        clk_en && !state_q.flt_n.s2 |=> clk_out_oe == '0)
        else $error("outputs driven while floated");
    drive_outputs_a: assert property ( // see R7
        clk_en && state_q.flt_n.s2 |=> &clk_out_oe)
        else $error("outputs not driven");
    outputs_equal_a: assert property ( // see R8
        clk_out == {NUM_OUT{clk_out[0]}})
        else $error("outputs differ");
    gate_move_low_a: assert property ( // see R9
        $changed(state_q.oe_cap) |-> !$past(sel_clk))
        else $error("gate moved while clock high");

    // routing of each source at both levels
    route_diff_clk_a: assert property ( // see R1
        clk_en && !state_q.sel.s2 && state_q.oe_cap && state_q.ref_p.s2 && !state_q.ref_n.s2
        |=> clk_out[0] == 1'b1)
        else $error("reference clock not routed");
    route_diff_low_a: assert property ( // see R1
        clk_en && !state_q.sel.s2 && !state_q.ref_p.s2 |=> clk_out[0] == 1'b0)
        else $error("reference low not routed");
    route_test_low_a: assert property ( // see R1
        clk_en && state_q.sel.s2 && !state_q.test.s2 |=> clk_out[0] == 1'b0)
        else $error("test clock low not routed");

    // the captured value is the synchronised pin seen at the falling edge
    capture_value_a: assert property ( // see R2
        clk_en && fall_det |=> state_q.oe_cap == $past(state_q.oe.s2))
        else $error("wrong enable captured");

    // an output rises only with the selected clock, never inside a high phase
    rise_with_clock_a: assert property ( // see R5, R9
        $rose(clk_out[0]) |-> $past(sel_clk) && !$past(state_q.sel_clk_prev))
        else $error("output rose inside a high phase");

    // clock enable low freezes the whole state
    freeze_hold_a: assert property (
        !clk_en |=> $stable(state_q))
        else $error("state moved while frozen");

    // the edge detector keeps the last sampled level
    prev_level_a: assert property (
        clk_en |=> state_q.sel_clk_prev == $past(sel_clk))
        else $error("edge detector lost level");

    // each synchroniser moves one stage per enabled edge
    oe_sync_step_a: assert property ( // see R2
        clk_en |=> state_q.oe.s2 == $past(state_q.oe.s1))
        else $error("enable synchroniser skipped a stage");
    flt_sync_step_a: assert property ( // see R6, R7
        clk_en |=> state_q.flt_n.s2 == $past(state_q.flt_n.s1))
        else $error("float synchroniser skipped a stage");
    sel_sync_step_a: assert property ( // see R1
        clk_en |=> state_q.sel.s2 == $past(state_q.sel.s1))
        else $error("select synchroniser skipped a stage");
    float_latency_a: assert property ( // see R6
        clk_en && !state_q.flt_n.s1 ##1 clk_en |=> clk_out_oe == '0)
        else $error("float not reaching outputs in time");

    // every output bit and enable bit matches bit zero
    for (genvar gi = 1; gi < NUM_OUT; gi++) begin : g_out_chk
        out_same_a: assert property ( // see R8
            clk_out[gi] == clk_out[0])
            else $error("clock output differs from output zero");
        oe_same_a: assert property ( // see R6, R7
            clk_out_oe[gi] == clk_out_oe[0])
            else $error("output enable differs from output zero");
    end

    // main scenarios worth seeing in a run
    enable_seen_c: cover property ($rose(state_q.oe_cap));
    disable_seen_c: cover property ($fell(state_q.oe_cap));
    test_toggle_c: cover property (state_q.sel.s2 && $rose(clk_out[0]));
    float_seen_c: cover property ($fell(clk_out_oe[0]));
    diff_toggle_c: cover property (!state_q.sel.s2 && $rose(clk_out[0]));

endmodule : cfs_fanout

/* sim/cfs_clk_src.sv */
// free-running reference and test clock sources
`timescale 1ns/1ps
module cfs_clk_src #(
    parameter int REF_HALF = 8,
    parameter int TST_HALF = 12
) (
    input wire logic sys_clk,
    output logic ref_clk,
    output logic tst_clk
);
    int rc_q = 0;
    int tc_q = 0;
    // edges land on the falling edge, away from the sampling edge
    always @(negedge sys_clk) begin
        rc_q <= (rc_q + 1) % (2 * REF_HALF);
        tc_q <= (tc_q + 1) % (2 * TST_HALF);
    end
    assign ref_clk = (rc_q < REF_HALF);
    assign tst_clk = (tc_q < TST_HALF);
endmodule : cfs_clk_src

/* sim/tb_clock_fanout_select_gate.sv */
// self-checking bench of the clock fan-out block
`timescale 1ns/1ps
module tb_clock_fanout_select_gate;
    logic sys_clk = 0;
    logic resetn = 0;
    logic sel = 0;
    logic oe = 0;
    logic flt_n = 0;
    logic ref_clk, tst_clk;
    logic [11:0] clk_out, clk_out_oe;
    int mismatches = 0;
    int checks_done = 0;
    int r, b;
    logic en = 1;
    // clock and devices
    initial forever #2.5 sys_clk = ~sys_clk;
    cfs_clk_src src (.sys_clk(sys_clk), .ref_clk(ref_clk), .tst_clk(tst_clk));
    cfs_fanout uut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(en), .diff_ref_clk_p(ref_clk),
        .diff_ref_clk_n(~ref_clk), .test_clk_in(tst_clk), .clk_source_select(sel),
        .sync_out_enable(oe), .output_float_n(flt_n), .clk_out(clk_out), .clk_out_oe(clk_out_oe));
    ////////////////////////////////////////
    task automatic cmp(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    // counts rises; a high run not half long after the first rise, or unequal outputs, is bad
    task automatic run(input int n, input int half, output int rises, output int bad);
        int hi;
        logic prev;
        hi = 0;
        rises = 0;
        bad = 0;
        prev = clk_out[0];
        repeat (n) begin
            @(negedge sys_clk);
            if (clk_out !== {12{clk_out[0]}}) bad++;
            if (clk_out[0] === 1'b1) begin
                if (!prev) rises++;
                hi++;
            end else begin
                if (prev && rises > 0 && hi != half) bad++;
                hi = 0;
            end
            prev = clk_out[0];
        end
    endtask : run
    task automatic t_float;
        flt_n = 0;
        repeat (6) @(negedge sys_clk);
        cmp("oe float", 12'h000, clk_out_oe);
        flt_n = 1;
        repeat (6) @(negedge sys_clk);
        cmp("oe drive", 12'hfff, clk_out_oe);
        flt_n = 0;
        repeat (6) @(negedge sys_clk);
        cmp("oe refloat", 12'h000, clk_out_oe);
        flt_n = 1;
        repeat (6) @(negedge sys_clk);
    endtask : t_float
    // clock enable low must freeze outputs and ignore the float pin
    task automatic t_freeze;
        logic [11:0] held;
        held = clk_out;
        en = 0;
        flt_n = 0;
        repeat (20) @(negedge sys_clk);
        cmp("frozen out", held, clk_out);
        cmp("frozen oe", 12'hfff, clk_out_oe);
        en = 1;
        repeat (6) @(negedge sys_clk);
        cmp("thawed oe", 12'h000, clk_out_oe);
        flt_n = 1;
        repeat (6) @(negedge sys_clk);
    endtask : t_freeze
    // waits until the reference pin is a few cycles into its high phase
    task automatic wait_ref_high;
        int k;
        k = 0;
        while (ref_clk !== 1'b0 && k < 40) begin
            @(negedge sys_clk);
            k++;
        end
        while (ref_clk !== 1'b1 && k < 40) begin
            @(negedge sys_clk);
            k++;
        end
        if (k >= 40) begin
            mismatches++;
            stop_test();
        end
        repeat (2) @(negedge sys_clk);
    endtask : wait_ref_high
    task automatic t_src(input logic s, input int half);
        sel = s;
        oe = 1;
        repeat (60) @(negedge sys_clk);
        run(480, half, r, b);
        cmp("rises", 12'(480 / (2 * half)), 12'(r));
        cmp("bad", 12'h000, 12'(b));
    endtask : t_src
    // enable moved inside a high phase must still leave only whole pulses
    task automatic t_gate;
        fork
            run(480, 8, r, b);
            begin
                wait_ref_high();
                oe = 0;
                repeat (40) @(negedge sys_clk);
                wait_ref_high();
                oe = 1;
                repeat (40) @(negedge sys_clk);
                wait_ref_high();
                oe = 0;
            end
        join
        cmp("gate bad", 12'h000, 12'(b));
        run(96, 8, r, b);
        cmp("parked", 12'h000, clk_out);
        cmp("parked rises", 12'h000, 12'(r));
    endtask : t_gate
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test
    // main sequence
    initial begin
        repeat (8) @(negedge sys_clk);
        resetn = 1;
        t_float();
        t_src(1'b0, 8);
        t_src(1'b1, 12);
        t_src(1'b0, 8);
        t_freeze();
        t_gate();
        stop_test();
    end
endmodule : tb_clock_fanout_select_gate
